// ---- design/mmr_defs.svh ----
// constants for the remote read/write request engine
// assumes a 100 MHz pclk and a byte-addressed APB bus
`ifndef MMR_DEFS_SVH
`define MMR_DEFS_SVH
`define MMR_OFF_CTRL      8'h00
`define MMR_OFF_STATION   8'h04
`define MMR_OFF_FUNC      8'h08
`define MMR_OFF_RADDR     8'h0C
`define MMR_OFF_LIDX      8'h10
`define MMR_OFF_LEN       8'h14
`define MMR_OFF_STATUS    8'h18
`define MMR_OFF_IRQ_STAT  8'h1C
`define MMR_OFF_IRQ_MASK  8'h20
`define MMR_OFF_DATA      8'h40
`define MMR_DATA_HI       8'h7C
`define MMR_CTRL_GO       0
`define MMR_CTRL_CONT     1
`define MMR_EV_DONE       0
`define MMR_EV_ERR        1
`define MMR_EV_TOUT       2
`define MMR_EV_REJECT     3
`define MMR_ST_BUSY       0
`define MMR_ST_FLAG_A     1
`define MMR_ST_FLAG_B     2
`define MMR_ST_FLAG_C     3
`define MMR_ST_REJECT     4
`define MMR_MAX_LEN       5'h10
`define MMR_ONE_LEN       5'h01
`define MMR_REMOTE_DIN    16'h0400
`define MMR_REMOTE_DOUT   16'h0500
`define MMR_REMOTE_TMR    16'h0600
`define MMR_REMOTE_AUX    16'h0800
`define MMR_REMOTE_CNT    16'h0E00
`define MMR_REMOTE_DREG   16'h1000
`define MMR_CLK_MHZ       100
`define MMR_TIMEOUT_US    10000
`endif

// ---- design/mmr_pkg.sv ----
// types shared by the remote read/write request engine
// assumes the constants header is compiled alongside
package mmr_pkg;
  typedef enum logic [7:0] {
    MMR_FC_BIT_RD   = 8'h02,
    MMR_FC_WORD_RD  = 8'h03,
    MMR_FC_WORD_WR1 = 8'h06,
    MMR_FC_COIL_WR  = 8'h0F,
    MMR_FC_WORD_WRN = 8'h10
  } mmr_func_t;

  typedef struct packed {
    logic [7:0]  station;
    logic [7:0]  func;
    logic [15:0] raddr;
    logic [4:0]  len;
  } mmr_req_t;

  typedef enum logic [3:0] {
    MMR_IDLE = 4'b0001,
    MMR_SEND = 4'b0010,
    MMR_WAIT = 4'b0100,
    MMR_DONE = 4'b1000
  } mmr_state_t;
endpackage

// ---- design/mmr_remote_rw.sv ----
// remote_rw_instruction engine: APB register front end and one-request link to a remote slave
// assumes the serial framing block sits on the link ports and answers in pclk cycles
//
// The register addresses and register access over APB were chosen for this implementation.
`include "mmr_defs.svh"
`timescale 1ns/10ps
module mmr_remote_rw
  import mmr_pkg::*;
#(
  parameter int TIMEOUT_CYC = `MMR_TIMEOUT_US * `MMR_CLK_MHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             req_valid,
  output mmr_req_t         req,
  output logic             tx_valid,
  output logic [15:0]      tx_data,
  input  wire logic        tx_ready,
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_data,
  input  wire logic        resp_done,
  input  wire logic        resp_err
);

  function automatic logic func_ok(input logic [7:0] f);
    func_ok = (f == MMR_FC_BIT_RD) || (f == MMR_FC_WORD_RD) || (f == MMR_FC_WORD_WR1) ||
              (f == MMR_FC_COIL_WR) || (f == MMR_FC_WORD_WRN);
  endfunction

  function automatic logic func_writes(input logic [7:0] f);
    func_writes = (f == MMR_FC_WORD_WR1) || (f == MMR_FC_COIL_WR) || (f == MMR_FC_WORD_WRN);
  endfunction

  function automatic logic [3:0] word_index(input logic [3:0] base, input logic [3:0] off);
    word_index = 4'(base + off);
  endfunction

  mmr_state_t  state_reg;
  logic        cont_reg;
  logic [7:0]  station_reg;
  logic [7:0]  func_reg;
  logic [15:0] raddr_reg;
  logic [3:0]  lidx_reg;
  logic [4:0]  len_reg;
  logic [4:0]  run_len_reg;
  logic [7:0]  run_func_reg;
  logic [3:0]  run_lidx_reg;
  logic [3:0]  item_reg;
  logic [3:0]  item_next;
  logic        flag_a_reg;
  logic        flag_b_reg;
  logic        flag_c_reg;
  logic        reject_reg;
  logic [3:0]  ev_stat_reg;
  logic [3:0]  ev_mask_reg;
  logic [3:0]  ev_set;
  logic [31:0] tout_reg;
  logic [15:0] mem_reg [16];
  logic        pready_reg;
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        irq_reg;
  logic        req_valid_reg;
  mmr_req_t    req_reg;
  logic        tx_valid_reg;
  logic [15:0] tx_data_reg;
  logic        go_pulse;
  logic        launch;
  logic        legal;
  logic [4:0]  eff_len;
  logic        bus_wr;
  logic        bus_rd;
  logic        data_hit;
  logic [3:0]  data_idx;
  logic        mapped;
  logic        tx_fire;
  logic        tx_last;
  logic        rx_take;
  logic        finish;

  assign bus_wr   = psel & penable & pwrite & pready_reg;
  assign bus_rd   = psel & penable & ~pwrite & ~pready_reg;
  assign data_hit = (paddr >= `MMR_OFF_DATA) && (paddr <= `MMR_DATA_HI) && (paddr[1:0] == 2'b00);
  assign data_idx = paddr[5:2];
  assign mapped   = data_hit || (paddr == `MMR_OFF_CTRL) || (paddr == `MMR_OFF_STATION) ||
                    (paddr == `MMR_OFF_FUNC) || (paddr == `MMR_OFF_RADDR) || (paddr == `MMR_OFF_LIDX) ||
                    (paddr == `MMR_OFF_LEN) || (paddr == `MMR_OFF_STATUS) ||
                    (paddr == `MMR_OFF_IRQ_STAT) || (paddr == `MMR_OFF_IRQ_MASK);

  // pulse form: one execution per write of the go bit made while idle; a write while busy is dropped
  assign go_pulse = bus_wr && (paddr == `MMR_OFF_CTRL) && pwdata[`MMR_CTRL_GO];
  // continuous form: relaunch every time the engine returns to idle while enabled
  assign launch   = (state_reg == MMR_IDLE) && (go_pulse || cont_reg);
  // single word write always carries exactly one item
  assign eff_len  = (func_reg == MMR_FC_WORD_WR1) ? `MMR_ONE_LEN : len_reg;
  assign legal    = func_ok(func_reg) && (eff_len != 5'h00) && (eff_len <= `MMR_MAX_LEN);
  assign tx_fire  = tx_valid_reg & tx_ready;
  assign tx_last  = (5'(item_reg) + 5'h01) == run_len_reg;
  assign rx_take  = (state_reg == MMR_WAIT) && rx_valid && !func_writes(run_func_reg) &&
                    (5'(item_reg) < run_len_reg);
  assign finish   = (state_reg == MMR_WAIT) && (resp_done || resp_err || (tout_reg == 32'h0000_0001));
  assign item_next = 4'(item_reg + 4'h1);

  always_comb begin
    ev_set = 4'h0;
    ev_set[`MMR_EV_DONE]   = finish && resp_done && !resp_err;
    ev_set[`MMR_EV_ERR]    = finish && resp_err;
    ev_set[`MMR_EV_TOUT]   = finish && !resp_done && !resp_err;
    ev_set[`MMR_EV_REJECT] = launch && !legal;
  end

  // request state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MMR_IDLE;
    end else begin
      unique case (state_reg)
        MMR_IDLE: begin
          if (launch && legal) begin
            state_reg <= func_writes(func_reg) ? MMR_SEND : MMR_WAIT;
          end
        end
        MMR_SEND: begin
          if (tx_fire && tx_last) begin
            state_reg <= MMR_WAIT;
          end
        end
        MMR_WAIT: begin
          if (finish) begin
            state_reg <= MMR_DONE;
          end
        end
        MMR_DONE: begin
          state_reg <= MMR_IDLE;
        end
      endcase
    end
  end

  // operands latched at launch so software may prepare the next request meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len_reg   <= 5'h00;
      run_func_reg  <= 8'h00;
      run_lidx_reg  <= 4'h0;
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else begin
      req_valid_reg <= 1'b0;
      if (launch && legal) begin
        run_len_reg   <= eff_len;
        run_func_reg  <= func_reg;
        run_lidx_reg  <= lidx_reg;
        req_valid_reg <= 1'b1;
        // remote address passes through untouched; slave area bases are the caller's choice
        req_reg <= '{station: station_reg, func: func_reg, raddr: raddr_reg, len: eff_len};
      end
    end
  end

  // item counter shared by the send and receive phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      item_reg <= 4'h0;
    end else if (launch && legal) begin
      item_reg <= 4'h0;
    end else if ((tx_fire && !tx_last) || rx_take) begin
      item_reg <= item_next;
    end else if (tx_fire) begin
      item_reg <= 4'h0;
    end
  end

  // outgoing data beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 16'h0000;
    end else if (launch && legal && func_writes(func_reg)) begin
      tx_valid_reg <= 1'b1;
      if (func_reg == MMR_FC_COIL_WR) begin
        tx_data_reg <= {15'h0000, mem_reg[lidx_reg][0]};
      end else begin
        tx_data_reg <= mem_reg[lidx_reg];
      end
    end else if (tx_fire) begin
      tx_valid_reg <= !tx_last;
      if (run_func_reg == MMR_FC_COIL_WR) begin
        tx_data_reg <= {15'h0000, mem_reg[run_lidx_reg][item_next]};
      end else begin
        tx_data_reg <= mem_reg[word_index(run_lidx_reg, item_next)];
      end
    end
  end

  // response watchdog, counting only in MMR_WAIT; a slave that never raises tx_ready still holds the port in MMR_SEND
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_reg <= 32'h0000_0000;
    end else if (launch && legal) begin
      tout_reg <= 32'(TIMEOUT_CYC);
    end else if (state_reg == MMR_WAIT && tout_reg != 32'h0000_0000) begin
      tout_reg <= tout_reg - 32'h0000_0001;
    end
  end

  // completion flags: clear beats set only if both could land in one cycle, which they cannot here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      flag_c_reg <= 1'b0;
      reject_reg <= 1'b0;
    end else if (launch) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      flag_c_reg <= 1'b0;
      reject_reg <= !legal;
    end else if (finish) begin
      flag_a_reg <= ev_set[`MMR_EV_DONE];
      flag_b_reg <= ev_set[`MMR_EV_ERR];
      flag_c_reg <= ev_set[`MMR_EV_TOUT];
    end
  end

  // local data registers; the link wins a same-cycle clash with the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        mem_reg[i] <= 16'h0000;
      end
    end else if (rx_take) begin
      if (run_func_reg == MMR_FC_BIT_RD) begin
        mem_reg[run_lidx_reg][item_reg] <= rx_data[0];
      end else begin
        mem_reg[word_index(run_lidx_reg, item_reg)] <= rx_data;
      end
    end else if (bus_wr && data_hit) begin
      mem_reg[data_idx] <= pwdata[15:0];
    end
  end

  // operand and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cont_reg    <= 1'b0;
      station_reg <= 8'h00;
      func_reg    <= 8'h00;
      raddr_reg   <= 16'h0000;
      lidx_reg    <= 4'h0;
      len_reg     <= 5'h00;
      ev_mask_reg <= 4'h0;
    end else if (bus_wr) begin
      unique case (paddr)
        `MMR_OFF_CTRL:     cont_reg    <= pwdata[`MMR_CTRL_CONT];
        `MMR_OFF_STATION:  station_reg <= pwdata[7:0];
        `MMR_OFF_FUNC:     func_reg    <= pwdata[7:0];
        `MMR_OFF_RADDR:    raddr_reg   <= pwdata[15:0];
        `MMR_OFF_LIDX:     lidx_reg    <= pwdata[3:0];
        `MMR_OFF_LEN:      len_reg     <= pwdata[4:0];
        `MMR_OFF_IRQ_MASK: ev_mask_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear; a new event wins over its clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_stat_reg <= 4'h0;
      irq_reg     <= 1'b0;
    end else begin
      if (bus_wr && paddr == `MMR_OFF_IRQ_STAT) begin
        ev_stat_reg <= (ev_stat_reg & ~pwdata[3:0]) | ev_set;
      end else begin
        ev_stat_reg <= ev_stat_reg | ev_set;
      end
      irq_reg <= |(ev_stat_reg & ev_mask_reg);
    end
  end

  // apb answer: one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      prdata_reg  <= 32'h0000_0000;
      if (bus_rd) begin
        if (data_hit) begin
          prdata_reg <= {16'h0000, mem_reg[data_idx]};
        end else begin
          unique case (paddr)
            `MMR_OFF_CTRL:     prdata_reg <= {30'h0000_0000, cont_reg, 1'b0};
            `MMR_OFF_STATION:  prdata_reg <= {24'h00_0000, station_reg};
            `MMR_OFF_FUNC:     prdata_reg <= {24'h00_0000, func_reg};
            `MMR_OFF_RADDR:    prdata_reg <= {16'h0000, raddr_reg};
            `MMR_OFF_LIDX:     prdata_reg <= {28'h000_0000, lidx_reg};
            `MMR_OFF_LEN:      prdata_reg <= {27'h000_0000, len_reg};
            `MMR_OFF_STATUS:   prdata_reg <= {27'h000_0000, reject_reg, flag_c_reg, flag_b_reg, flag_a_reg,
                                              state_reg != MMR_IDLE};
            `MMR_OFF_IRQ_STAT: prdata_reg <= {28'h000_0000, ev_stat_reg};
            `MMR_OFF_IRQ_MASK: prdata_reg <= {28'h000_0000, ev_mask_reg};
            default:           prdata_reg <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign irq       = irq_reg;
  assign req_valid = req_valid_reg;
  assign req       = req_reg;
  assign tx_valid  = tx_valid_reg;
  assign tx_data   = tx_data_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_func_gate: assert property (req_valid |-> func_ok(req.func))
    else $error("request sent with unsupported function code");
  a_bad_no_req: assert property ((launch && !func_ok(func_reg)) |=> !req_valid && state_reg == MMR_IDLE)
    else $error("unsupported code left idle");
  a_flags_clear: assert property (launch |=> !flag_a_reg && !flag_b_reg && !flag_c_reg)
    else $error("flags not cleared on execution");
  a_one_request: assert property (req_valid |-> $past(state_reg) == MMR_IDLE && state_reg != MMR_IDLE)
    else $error("second request while one outstanding");
  a_len_latched: assert property (req_valid |-> req.len == run_len_reg && req.len != 5'h00)
    else $error("request length differs from run length");
  a_single_len: assert property ((req_valid && req.func == MMR_FC_WORD_WR1) |-> req.len == `MMR_ONE_LEN)
    else $error("single word write not of one item");
  a_done_flag: assert property ((finish && resp_done && !resp_err) |=> flag_a_reg && !flag_b_reg)
    else $error("correct completion not reported");
  a_err_flag: assert property ((finish && resp_err) |=> flag_b_reg && !flag_a_reg)
    else $error("failed completion not reported");
  a_bit_pack: assert property ((rx_take && run_func_reg == MMR_FC_BIT_RD) |=>
                               mem_reg[run_lidx_reg][$past(item_reg)] == $past(rx_data[0]))
    else $error("bit read not packed into destination");
  a_cont_rerun: assert property ((state_reg == MMR_IDLE && cont_reg && legal) |=> req_valid)
    else $error("continuous form did not repeat");

  c_word_read: cover property (req_valid && req.func == MMR_FC_WORD_RD ##[1:50] resp_done);
  c_coil_write: cover property (req_valid && req.func == MMR_FC_COIL_WR ##[1:50] state_reg == MMR_WAIT);
  c_timeout: cover property (finish && !resp_done && !resp_err);
  c_reject: cover property (launch && !legal);

endmodule

// ---- test/mmr_slave_model.sv ----
// behavioural remote slave for the request engine link
// assumes one-cycle req_valid pulses and a single pclk domain
// link owner, rate and format taken as already agreed with the engine
`timescale 1ns/10ps
module mmr_slave_model
  import mmr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        req_valid,
  input  wire mmr_req_t    req,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [15:0]      rx_data,
  output logic             resp_done,
  output logic             resp_err,
  input  wire logic [1:0]  mode,
  input  wire logic [31:0] delay
);
  localparam logic [15:0] WORD_BASE = 16'hA500;
  localparam logic [15:0] BIT_PAT   = 16'h000B;
  mmr_req_t    cur;
  logic [15:0] tx_log[$];
  int          n_req = 0;
  int          nb;
  // counted apart from the serving loop so a launch while busy is still seen
  always @(posedge pclk) begin
    if (req_valid === 1'b1) n_req++;
  end
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'h5A5A;
    resp_done = 1'b0;
    resp_err = 1'b0;
    forever begin
      @(posedge pclk);
      if (req_valid === 1'b1) begin
        cur = req;
        repeat (delay) @(posedge pclk);
        // remote address taken as given, slave areas 0x400..0x1000
        if (cur.func == MMR_FC_BIT_RD || cur.func == MMR_FC_WORD_RD) begin
          for (int i = 0; i < cur.len && mode != 2'd2; i++) begin
            rx_valid <= 1'b1;
            rx_data <= (cur.func == MMR_FC_BIT_RD) ? {15'h0, BIT_PAT[i]} : WORD_BASE + 16'(i);
            @(posedge pclk);
          end
          rx_valid <= 1'b0;
          // released line shows the inverse, not a stale item
          rx_data <= ~rx_data;
        end else begin
          nb = (cur.func == MMR_FC_WORD_WR1) ? 1 : int'(cur.len);
          tx_ready <= 1'b1;
          while (nb > 0) begin
            @(posedge pclk);
            if (tx_valid === 1'b1) begin
              tx_log.push_back(tx_data);
              nb--;
            end
          end
          tx_ready <= 1'b0;
        end
        // silent mode leaves the engine to its own timeout
        if (mode != 2'd2) begin
          resp_done <= (mode == 2'd0);
          resp_err <= (mode == 2'd1);
          @(posedge pclk);
          resp_done <= 1'b0;
          resp_err <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- test/tb_mmr_remote_rw.sv ----
// self-checking bench for the remote read/write request engine
// assumes one slave model on the link and APB driven from this module
`include "mmr_defs.svh"
`timescale 1ns/10ps
module tb_mmr_remote_rw;
  import mmr_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        req_valid, tx_valid, tx_ready, rx_valid, resp_done, resp_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tx_data, rx_data;
  logic [1:0]  mode;
  mmr_req_t    req;
  int          delay, bad_count, n_compared, n0;

  mmr_remote_rw #(.TIMEOUT_CYC(200)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .req_valid(req_valid), .req(req), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .resp_done(resp_done), .resp_err(resp_err));
  mmr_slave_model m (.pclk(pclk), .req_valid(req_valid), .req(req), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data), .resp_done(resp_done), .resp_err(resp_err),
    .mode(mode), .delay(delay));

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until pready is sampled high; no fixed wait assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) bad_count++;
  endtask

  task automatic cfg(input logic [7:0] st, fc, input logic [15:0] ra, input logic [3:0] li, input logic [4:0] ln);
    apb(1, `MMR_OFF_STATION, {24'h0, st});
    apb(1, `MMR_OFF_FUNC, {24'h0, fc});
    apb(1, `MMR_OFF_RADDR, {16'h0, ra});
    apb(1, `MMR_OFF_LIDX, {28'h0, li});
    apb(1, `MMR_OFF_LEN, {27'h0, ln});
  endtask

  task automatic settle;
    int n;
    n = 0;
    do begin
      apb(0, `MMR_OFF_STATUS, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 400);
    if (n >= 400) bad_count++;
    apb(0, `MMR_OFF_STATUS, 0);
  endtask

  task automatic run(input logic [7:0] st, fc, input logic [15:0] ra, input logic [3:0] li, input logic [4:0] ln);
    cfg(st, fc, ra, li, ln);
    apb(1, `MMR_OFF_CTRL, 32'h1);
    settle();
  endtask

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, mode} = '0;
    delay = 1;
    bad_count = 0;
    n_compared = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `MMR_OFF_STATUS, 0);
    chk("status_rst", rd, 32'h0);
    apb(0, 8'h30, 0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    n0 = m.n_req;
    run(8'h14, MMR_FC_WORD_RD, `MMR_REMOTE_DREG, 4'd3, 5'd2);
    chk("rd_ok", rd, 32'h2);
    chk("pulse_once", m.n_req - n0, 1);
    chk("hdr", {m.cur.station, m.cur.func, m.cur.raddr}, {8'h14, 8'h03, `MMR_REMOTE_DREG});
    apb(0, 8'h4C, 0);
    chk("word0", rd, 32'hA500);
    apb(0, 8'h50, 0);
    chk("word1", rd, 32'hA501);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1, `MMR_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1, `MMR_OFF_IRQ_STAT, 32'hF);
    repeat (2) @(posedge pclk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1, 8'h40, 32'h0);
    run(8'h14, MMR_FC_BIT_RD, `MMR_REMOTE_DIN, 4'd0, 5'd4);
    apb(0, 8'h40, 0);
    chk("bits", rd, 32'h000B);
    chk("area_din", {16'h0, m.cur.raddr}, {16'h0, `MMR_REMOTE_DIN});
    run(8'h14, MMR_FC_BIT_RD, `MMR_REMOTE_AUX, 4'd2, 5'd4);
    chk("area_aux", {16'h0, m.cur.raddr}, {16'h0, `MMR_REMOTE_AUX});
    run(8'h14, MMR_FC_WORD_RD, `MMR_REMOTE_TMR, 4'd8, 5'd4);
    chk("area_tmr", {16'h0, m.cur.raddr}, {16'h0, `MMR_REMOTE_TMR});
    run(8'h14, MMR_FC_WORD_RD, `MMR_REMOTE_CNT, 4'd14, 5'd4);
    chk("area_cnt", {16'h0, m.cur.raddr}, {16'h0, `MMR_REMOTE_CNT});
    // items 2 and 3 of a run from local word 14 wrap to words 0 and 1
    apb(0, 8'h40, 0);
    chk("word_wrap", rd, 32'hA502);
    apb(1, 8'h44, 32'h000A);
    n0 = m.tx_log.size();
    run(8'h14, MMR_FC_COIL_WR, `MMR_REMOTE_DOUT, 4'd1, 5'd4);
    for (int i = 0; i < 4; i++) chk("coil", {31'h0, m.tx_log[n0 + i][0]}, {31'h0, i[0]});
    chk("area_dout", {16'h0, m.cur.raddr}, {16'h0, `MMR_REMOTE_DOUT});
    apb(1, 8'h54, 32'h1234);
    apb(1, 8'h58, 32'h5678);
    n0 = m.tx_log.size();
    run(8'h0A, MMR_FC_WORD_WRN, 16'h0500, 4'd5, 5'd2);
    chk("wr0", {16'h0, m.tx_log[n0]}, 32'h1234);
    chk("wr1", {16'h0, m.tx_log[n0 + 1]}, 32'h5678);
    run(8'h0A, MMR_FC_WORD_WR1, 16'h2000, 4'd5, 5'd1);
    chk("wr_single", {16'h0, m.tx_log[n0 + 2]}, 32'h1234);
    chk("wr_single_ok", rd, 32'h2);
    n0 = m.n_req;
    run(8'h0A, 8'h05, 16'h0, 4'd0, 5'd1);
    chk("rej_code", rd, 32'h10);
    run(8'h0A, MMR_FC_WORD_RD, 16'h0, 4'd0, 5'd0);
    chk("rej_len0", rd, 32'h10);
    run(8'h0A, MMR_FC_WORD_RD, 16'h0, 4'd0, 5'h11);
    chk("rej_len17", rd, 32'h10);
    chk("rej_noreq", m.n_req - n0, 0);
    apb(0, `MMR_OFF_IRQ_STAT, 0);
    chk("rej_event", rd & 32'h8, 32'h8);
    mode = 2'd1;
    run(8'h0A, MMR_FC_WORD_RD, 16'h0, 4'd0, 5'd1);
    chk("resp_err", rd, 32'h4);
    mode = 2'd2;
    run(8'h0A, MMR_FC_WORD_RD, 16'h0, 4'd0, 5'd1);
    chk("timeout", rd, 32'h8);
    mode = 2'd0;
    delay = 20;
    apb(1, `MMR_OFF_CTRL, 32'h1);
    apb(0, `MMR_OFF_STATUS, 0);
    chk("flags_cleared", rd, 32'h1);
    n0 = m.n_req;
    apb(1, `MMR_OFF_CTRL, 32'h1);
    chk("one_outstanding", m.n_req - n0, 0);
    settle();
    chk("after_busy", rd, 32'h2);
    delay = 1;
    n0 = m.n_req;
    apb(1, `MMR_OFF_CTRL, 32'h2);
    repeat (60) @(posedge pclk);
    apb(1, `MMR_OFF_CTRL, 32'h0);
    settle();
    chk("continuous", {31'h0, (m.n_req - n0) >= 2}, 32'h1);
    final_report();
  end
endmodule
